// ==== core/bertc_top.sv ====
// bit-error test channel configuration, window selection and error counting
// assumes the register port and the slot/data inputs are synchronous to i_clk,
// prepared by the device's processor interface and tdm front end
`timescale 1ns/10ps
`include "bertc_defines.svh"

module bertc_top (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  // processor register port
  input  wire logic                          i_reg_sel,
  input  wire logic                          i_reg_read,
  input  wire logic [`BERTC_ADDR_W-1:0]      i_reg_addr,
  input  wire logic [`BERTC_DATA_W-1:0]      i_reg_wdata,
  output logic      [`BERTC_DATA_W-1:0]      o_reg_rdata,
  output logic                               o_reg_ack,
  // control bits held elsewhere
  input  wire logic                          i_local_high_rate_select,
  input  wire logic                          i_local_count_clear,
  input  wire bertc_pkg::bertc_start_type    i_local_tx_start,
  input  wire logic [`BERTC_LEN_MSB:0]       i_bp_tx_extra_channels,
  // tdm slots
  input  wire bertc_pkg::bertc_slot_type     i_local_tx_slot,
  input  wire bertc_pkg::bertc_slot_type     i_bp_tx_slot,
  input  wire bertc_pkg::bertc_rx_type       i_local_rx,
  // test sequence insertion and error state
  output logic                               o_local_tx_insert,
  output logic                               o_bp_tx_insert,
  output logic      [`BERTC_CNT_W-1:0]       o_local_error_tally
);

  localparam int LW = `BERTC_LEN_MSB + 1;

  // true when the slot lies in [start, start + extra]; the window does not wrap past channel 511
  function automatic logic in_window(input bertc_pkg::bertc_slot_type s,
                                     input bertc_pkg::bertc_start_type st,
                                     input logic [LW-1:0] extra);
    logic [LW:0] last;
    last = {1'b0, st.channel} + {1'b0, extra};
    in_window = s.valid && (s.stream == st.stream) && (s.channel >= st.channel)
                && ({1'b0, s.channel} <= last);
  endfunction : in_window

  function automatic logic [`BERTC_INC_W-1:0] ones(input logic [7:0] v);
    logic [`BERTC_INC_W-1:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n = n + {{(`BERTC_INC_W - 1){1'b0}}, v[i]};
    end
    ones = n;
  endfunction : ones

  // register storage, field bits only; reserved bits read back as zero
  logic [`BERTC_LEN_MSB:0]       ltx_len_q;
  logic [`BERTC_LEN_MSB:0]       lrx_len_q;
  logic [`BERTC_LRX_START_MSB:0] lrx_start_q;
  logic [`BERTC_BTX_START_MSB:0] btx_start_q;
  logic [`BERTC_DATA_W-1:0]      rdata_q;
  logic                          ack_q;
  logic                          ltx_ins_q;
  logic                          btx_ins_q;
  logic                          rx_hit_q;
  logic [`BERTC_INC_W-1:0]       inc_q;
  logic [`BERTC_CNT_W-1:0]       count;

  wire logic wr        = i_reg_sel && !i_reg_read;
  wire logic wr_ltx    = wr && (i_reg_addr == `BERTC_OFF_LTX_LEN);
  wire logic wr_lrx    = wr && (i_reg_addr == `BERTC_OFF_LRX_LEN);
  wire logic wr_lstart = wr && (i_reg_addr == `BERTC_OFF_LRX_START);
  wire logic wr_bstart = wr && (i_reg_addr == `BERTC_OFF_BTX_START);

  // receive start decode depends on the local rate mode
  bertc_pkg::bertc_start_type lrx_start;
  assign lrx_start.stream = i_local_high_rate_select
    ? {1'b0, lrx_start_q[`BERTC_LRX_START_MSB:`BERTC_LRX_STR_LO_HR]}
    : lrx_start_q[`BERTC_LRX_START_MSB:`BERTC_LRX_STR_LO];
  assign lrx_start.channel = i_local_high_rate_select
    ? lrx_start_q[`BERTC_LRX_CH_MSB_HR:0]
    : {1'b0, lrx_start_q[`BERTC_LRX_CH_MSB:0]};

  bertc_pkg::bertc_start_type btx_start;
  assign btx_start.stream  = btx_start_q[`BERTC_BTX_START_MSB:`BERTC_BTX_STR_LO];
  assign btx_start.channel = btx_start_q[`BERTC_BTX_CH_MSB:0];

  // windows: a zero length still covers the start channel
  wire logic ltx_hit = in_window(i_local_tx_slot, i_local_tx_start, ltx_len_q);
  wire logic btx_hit = in_window(i_bp_tx_slot, btx_start, i_bp_tx_extra_channels);
  wire logic rx_hit  = in_window(i_local_rx.slot, lrx_start, lrx_len_q);
  wire logic [`BERTC_INC_W-1:0] rx_errs =
    rx_hit ? ones(i_local_rx.data ^ i_local_rx.expect_data) : '0;

  logic [`BERTC_DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = `BERTC_REG_RESET;
    unique case (i_reg_addr)
      `BERTC_OFF_LTX_LEN:    rd_mux[`BERTC_LEN_MSB:0]       = ltx_len_q;
      `BERTC_OFF_LRX_LEN:    rd_mux[`BERTC_LEN_MSB:0]       = lrx_len_q;
      `BERTC_OFF_LRX_START:  rd_mux[`BERTC_LRX_START_MSB:0] = lrx_start_q;
      `BERTC_OFF_LERR_COUNT: rd_mux                          = count;
      `BERTC_OFF_BTX_START:  rd_mux[`BERTC_BTX_START_MSB:0] = btx_start_q;
      default:               rd_mux                          = `BERTC_REG_RESET;
    endcase
  end

  // reserved bits are dropped on write; software is expected to write them as zero
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ltx_len_q   <= '0;
      lrx_len_q   <= '0;
      lrx_start_q <= '0;
      btx_start_q <= '0;
    end else begin
      if (wr_ltx)    ltx_len_q   <= i_reg_wdata[`BERTC_LEN_MSB:0];
      if (wr_lrx)    lrx_len_q   <= i_reg_wdata[`BERTC_LEN_MSB:0];
      if (wr_lstart) lrx_start_q <= i_reg_wdata[`BERTC_LRX_START_MSB:0];
      if (wr_bstart) btx_start_q <= i_reg_wdata[`BERTC_BTX_START_MSB:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= '0;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= (i_reg_sel && i_reg_read) ? rd_mux : '0;
      ack_q   <= i_reg_sel;
    end
  end

  // one pipeline stage keeps the slot decode off the counter adder path
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ltx_ins_q <= 1'b0;
      btx_ins_q <= 1'b0;
      rx_hit_q  <= 1'b0;
      inc_q     <= '0;
    end else begin
      ltx_ins_q <= ltx_hit;
      btx_ins_q <= btx_hit;
      rx_hit_q  <= rx_hit;
      inc_q     <= rx_errs;
    end
  end

  // the counter has no write path from the register port
  bertc_err_counter #(
    .WIDTH (`BERTC_CNT_W),
    .INC_W (`BERTC_INC_W)
  ) u_err_counter (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (i_local_count_clear),
    .i_inc     (inc_q),
    .o_count   (count)
  );

  assign o_reg_rdata         = rdata_q;
  assign o_reg_ack           = ack_q;
  assign o_local_tx_insert   = ltx_ins_q;
  assign o_bp_tx_insert      = btx_ins_q;
  assign o_local_error_tally = count;

  // checks
  property p_ltx_start;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_local_tx_slot.valid && i_local_tx_slot.stream == i_local_tx_start.stream
       && i_local_tx_slot.channel == i_local_tx_start.channel) |=> o_local_tx_insert;
  endproperty
  a_ltx_start: assert property (p_ltx_start) else $error("local start channel not sent");

  property p_ltx_end;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_local_tx_slot.valid && {1'b0, i_local_tx_slot.channel}
       == {1'b0, i_local_tx_start.channel} + {1'b0, ltx_len_q} + 10'h001) |=> !o_local_tx_insert;
  endproperty
  a_ltx_end: assert property (p_ltx_end) else $error("local transmit ran past its length");

  property p_rx_end;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_local_rx.slot.valid && {1'b0, i_local_rx.slot.channel}
       == {1'b0, lrx_start.channel} + {1'b0, lrx_len_q} + 10'h001) |=> !rx_hit_q;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("local receive checked past its length");

  property p_rx_other_stream;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_local_rx.slot.stream != lrx_start.stream) |=> (inc_q == '0);
  endproperty
  a_rx_other_stream: assert property (p_rx_other_stream) else $error("errors counted on wrong stream");

  property p_rx_hr_start;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_local_high_rate_select && i_local_rx.slot.valid
       && i_local_rx.slot.stream == {1'b0, lrx_start_q[12:9]}
       && i_local_rx.slot.channel == lrx_start_q[8:0]) |=> rx_hit_q;
  endproperty
  a_rx_hr_start: assert property (p_rx_hr_start) else $error("high-rate start not checked");

  property p_rx_lr_start;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!i_local_high_rate_select && i_local_rx.slot.valid
       && i_local_rx.slot.stream == lrx_start_q[12:8]
       && i_local_rx.slot.channel == {1'b0, lrx_start_q[7:0]}) |=> rx_hit_q;
  endproperty
  a_rx_lr_start: assert property (p_rx_lr_start) else $error("start channel not checked");

  property p_rx_all_wrong;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rx_hit && (i_local_rx.data ^ i_local_rx.expect_data) == 8'hFF) |=> (inc_q == 4'h8);
  endproperty
  a_rx_all_wrong: assert property (p_rx_all_wrong) else $error("bit errors miscounted");

  property p_count_ro;
    @(posedge i_clk) disable iff (i_sys_rst)
      (wr && i_reg_addr == `BERTC_OFF_LERR_COUNT && inc_q == '0 && !i_local_count_clear)
      |=> $stable(o_local_error_tally);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("error count changed by a write");

  property p_bp_start;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_bp_tx_slot.valid && i_bp_tx_slot.stream == btx_start_q[13:9]
       && i_bp_tx_slot.channel == btx_start_q[8:0]) |=> o_bp_tx_insert;
  endproperty
  a_bp_start: assert property (p_bp_start) else $error("backplane start not sent");

endmodule : bertc_top

// ==== pkg/bertc_defines.svh ====
// register offsets, field positions and reset values of the bit-error test channel block
// assumes inclusion by the package, the design modules and the bench
//
// Behaviour
// - The local transmit length field counts channels beyond the start channel, so length plus one channels are sent.
// - The local test transmitter sends at least one channel per frame, which it does when its length field is zero.
// - The local receive length field counts channels beyond the start channel, so length plus one channels are checked.
// - The local test receiver checks at least one channel per frame, which it does when its length field is zero.
// - Outside high-rate mode the receive start stream is bits 12:8 and the receive start channel bits 7:0.
// - In high-rate mode the receive start stream is bits 12:9 and the receive start channel bits 8:0.
// - Received test data is compared only on the local input stream chosen by the receive stream field.
// - Comparison starts at the local input channel chosen by the receive channel field.
// - The 16-bit local error counter is read-only, ignores writes and resets to zero.
// - The local error counter stops at all ones instead of wrapping.
// - Software clears the local error counter, also from saturation, through the local count-clear bit.
// - The backplane output stream carrying the test sequence is bits 13:9 of the backplane send start register.
// - The backplane test sequence starts at the output channel in bits 8:0 of the backplane send start register.
`ifndef BERTC_DEFINES_SVH
`define BERTC_DEFINES_SVH

`define BERTC_ADDR_W           14
`define BERTC_DATA_W           16
`define BERTC_OFF_LTX_LEN      14'h00C4
`define BERTC_OFF_LRX_LEN      14'h00C5
`define BERTC_OFF_LRX_START    14'h00C6
`define BERTC_OFF_LERR_COUNT   14'h00C7
`define BERTC_OFF_BTX_START    14'h00C8
`define BERTC_LEN_MSB          8
`define BERTC_LRX_START_MSB    12
`define BERTC_LRX_STR_LO       8
`define BERTC_LRX_STR_LO_HR    9
`define BERTC_LRX_CH_MSB       7
`define BERTC_LRX_CH_MSB_HR    8
`define BERTC_BTX_START_MSB    13
`define BERTC_BTX_STR_LO       9
`define BERTC_BTX_CH_MSB       8
`define BERTC_REG_RESET        16'h0000
`define BERTC_CNT_W            16
`define BERTC_INC_W            4

`endif

// ==== pkg/bertc_pkg.sv ====
// types shared by the bit-error test channel block
// assumes bertc_defines.svh on the include path
`include "bertc_defines.svh"

package bertc_pkg;

  // one time slot of a tdm stream, as seen by the front end
  typedef struct packed {
    logic       valid;
    logic [4:0] stream;
    logic [8:0] channel;
  } bertc_slot_type;

  // start position of a test window
  typedef struct packed {
    logic [4:0] stream;
    logic [8:0] channel;
  } bertc_start_type;

  // received channel byte with the expected test byte beside it
  typedef struct packed {
    bertc_slot_type slot;
    logic [7:0]     data;
    logic [7:0]     expect_data;
  } bertc_rx_type;

endpackage : bertc_pkg

// ==== core/bertc_err_counter.sv ====
// saturating error counter with synchronous clear
// assumes increments and clear are synchronous to i_clk
`timescale 1ns/10ps
`include "bertc_defines.svh"

module bertc_err_counter #(
  parameter int WIDTH = `BERTC_CNT_W,
  parameter int INC_W = `BERTC_INC_W
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // control
  input  wire logic             i_clear,
  input  wire logic [INC_W-1:0] i_inc,
  // count
  output logic      [WIDTH-1:0] o_count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] base;
  logic [WIDTH:0]   sum;
  logic [WIDTH-1:0] count_d;

  // clear first, then add: errors seen in the clear cycle are kept
  assign base    = i_clear ? '0 : count_q;
  assign sum     = {1'b0, base} + {{(WIDTH + 1 - INC_W){1'b0}}, i_inc};
  assign count_d = sum[WIDTH] ? '1 : sum[WIDTH-1:0];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

  property p_cnt_no_wrap;
    @(posedge i_clk) disable iff (i_sys_rst)
      (count_q == '1 && !i_clear) |=> (count_q == '1);
  endproperty
  a_cnt_no_wrap: assert property (p_cnt_no_wrap) else $error("error counter wrapped");

  property p_cnt_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_clear && i_inc == '0) |=> (count_q == '0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("error counter not cleared");

endmodule : bertc_err_counter

// ==== dv/bertc_stream_model.sv ====
// tdm slot source standing in for the device's serial front end
// assumes the bench calls burst at its falling-edge stimulus points
`timescale 1ns/10ps

module bertc_stream_model (
  // clock
  input  wire logic                 i_clk,
  // slots towards the block
  output bertc_pkg::bertc_slot_type o_local_tx_slot,
  output bertc_pkg::bertc_slot_type o_bp_tx_slot,
  output bertc_pkg::bertc_rx_type   o_local_rx
);
  initial begin
    o_local_tx_slot = '0;
    o_bp_tx_slot    = '0;
    o_local_rx      = '0;
  end

  // kind 0 local tx, 1 backplane tx, 2 local rx; err flips bits of the test byte
  task automatic burst(input int kind, input logic [4:0] st, input logic [8:0] ch,
                       input int n, input logic [7:0] err);
    bertc_pkg::bertc_slot_type s;
    for (int k = 0; k < n; k++) begin
      @(negedge i_clk);
      s = {1'b1, st, ch + 9'(k)};
      if (kind == 0) o_local_tx_slot = s;
      else if (kind == 1) o_bp_tx_slot = s;
      else o_local_rx = {s, 8'hA5 ^ err, 8'hA5};
    end
    @(negedge i_clk);
    // idle slots show the inverse of the last value so stale data cannot match
    o_local_tx_slot = {1'b0, ~o_local_tx_slot[13:0]};
    o_bp_tx_slot    = {1'b0, ~o_bp_tx_slot[13:0]};
    o_local_rx      = {1'b0, ~o_local_rx[29:0]};
  endtask : burst
endmodule : bertc_stream_model

// ==== dv/bertc_top_tb.sv ====
// self-checking bench for the bit-error test channel block
// assumes bertc_stream_model as the slot source and the defines on the include path
`timescale 1ns/10ps
`include "bertc_defines.svh"

module bertc_top_tb;
  // writable bits of the five registers from 0x00C4 up; the error count has none
  function automatic logic [15:0] rmask(input int i);
    case (i)
      0, 1:    rmask = 16'h01FF;
      2:       rmask = 16'h1FFF;
      4:       rmask = 16'h3FFF;
      default: rmask = 16'h0000;
    endcase
  endfunction : rmask

  logic                       i_clk = 1'b0;
  logic                       i_sys_rst, sel, rd, hr, clr;
  logic [13:0]                addr;
  logic [15:0]                wdata, rdata, tally;
  logic                       ack, tx_ins, bp_ins;
  logic [8:0]                 bp_len;
  bertc_pkg::bertc_start_type tx_start;
  bertc_pkg::bertc_slot_type  tx_slot, bp_slot;
  bertc_pkg::bertc_rx_type    rx;
  int                         miscompares = 0, cmp_count = 0, n_tx, n_bp;
  int                         tx_seen = 0, bp_seen = 0;

  always #12.5 i_clk = ~i_clk;
  // running totals have this one writer; each run takes the difference
  always @(posedge i_clk) begin
    if (tx_ins === 1'b1) tx_seen <= tx_seen + 1;
    if (bp_ins === 1'b1) bp_seen <= bp_seen + 1;
  end

  bertc_stream_model bertc_stream_model_inst (.i_clk(i_clk), .o_local_tx_slot(tx_slot),
    .o_bp_tx_slot(bp_slot), .o_local_rx(rx));
  bertc_top bertc_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_sel(sel), .i_reg_read(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_local_high_rate_select(hr), .i_local_count_clear(clr), .i_local_tx_start(tx_start),
    .i_bp_tx_extra_channels(bp_len), .i_local_tx_slot(tx_slot), .i_bp_tx_slot(bp_slot),
    .i_local_rx(rx), .o_local_tx_insert(tx_ins), .o_bp_tx_insert(bp_ins), .o_local_error_tally(tally));

  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk16

  task automatic reg_acc(input logic r, input logic [13:0] a, input logic [15:0] d);
    @(negedge i_clk);
    sel = 1'b1; rd = r; addr = a; wdata = d;
    @(negedge i_clk);
    sel = 1'b0;
    chk16(16'h0001, {15'h0, ack});
  endtask : reg_acc

  task automatic reg_chk(input logic [13:0] a, input logic [15:0] e);
    reg_acc(1'b1, a, 16'h0000);
    chk16(e, rdata);
  endtask : reg_chk

  task automatic run(input int kind, input logic [4:0] st, input logic [8:0] ch, input int n,
                     input logic [7:0] err);
    int tx0;
    int bp0;
    tx0 = tx_seen;
    bp0 = bp_seen;
    bertc_stream_model_inst.burst(kind, st, ch, n, err);
    repeat (3) @(negedge i_clk);
    n_tx = tx_seen - tx0;
    n_bp = bp_seen - bp0;
  endtask : run

  task automatic t_regs;
    for (int i = 0; i < 5; i++) reg_chk(14'h00C4 + 14'(i), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      reg_acc(1'b0, 14'h00C4 + 14'(i), 16'hFFFF);
      reg_chk(14'h00C4 + 14'(i), rmask(i));
    end
    reg_acc(1'b0, 14'h0100, 16'hFFFF);
    reg_chk(14'h0100, 16'h0000);
    for (int i = 0; i < 5; i++) reg_acc(1'b0, 14'h00C4 + 14'(i), 16'h0000);
    $display("registers test done");
  endtask : t_regs

  task automatic t_tx;
    tx_start = '{stream: 5'h03, channel: 9'h010};
    reg_acc(1'b0, 14'h00C4, 16'h0002);
    run(0, 5'h03, 9'h00F, 6, 8'h00); chk16(16'd3, 16'(n_tx));
    run(0, 5'h04, 9'h010, 3, 8'h00); chk16(16'd0, 16'(n_tx));
    reg_acc(1'b0, 14'h00C4, 16'h0000);
    run(0, 5'h03, 9'h00F, 4, 8'h00); chk16(16'd1, 16'(n_tx));
    reg_acc(1'b0, 14'h00C8, 16'h2705);
    bp_len = 9'h003;
    run(1, 5'h13, 9'h104, 6, 8'h00); chk16(16'd4, 16'(n_bp));
    run(1, 5'h12, 9'h105, 4, 8'h00); chk16(16'd0, 16'(n_bp));
    $display("transmit window test done");
  endtask : t_tx

  task automatic t_rx;
    reg_acc(1'b0, 14'h00C5, 16'h0001);
    reg_acc(1'b0, 14'h00C6, 16'h0B20);
    run(2, 5'h0B, 9'h01F, 4, 8'h07); chk16(16'd6, tally);
    run(2, 5'h0A, 9'h020, 2, 8'h07); chk16(16'd6, tally);
    hr = 1'b1;
    run(2, 5'h05, 9'h11F, 4, 8'h01); chk16(16'd8, tally);
    reg_acc(1'b0, 14'h00C7, 16'h0000);
    reg_chk(14'h00C7, 16'd8);
    hr = 1'b0;
    reg_acc(1'b0, 14'h00C5, 16'h0000);
    run(2, 5'h0B, 9'h020, 3, 8'h01); chk16(16'd9, tally);
    $display("receive window test done");
  endtask : t_rx

  task automatic t_sat;
    reg_acc(1'b0, 14'h00C5, 16'h01FF);
    reg_acc(1'b0, 14'h00C6, 16'h0000);
    @(negedge i_clk) clr = 1'b1;
    @(negedge i_clk) clr = 1'b0;
    repeat (15) run(2, 5'h00, 9'h000, 512, 8'hFF);
    chk16(16'hF000, tally);
    run(2, 5'h00, 9'h000, 512, 8'hFF); chk16(16'hFFFF, tally);
    run(2, 5'h00, 9'h000, 4, 8'hFF); chk16(16'hFFFF, tally);
    // clear comes from a control bit held outside this block
    @(negedge i_clk) clr = 1'b1;
    @(negedge i_clk) clr = 1'b0;
    @(negedge i_clk);
    chk16(16'h0000, tally);
    $display("saturation test done");
  endtask : t_sat

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    // roughly 8500 cycles of tests, so 40000, nearly five times that, is a hang
    #(40000 * 25);
    miscompares++;
    report_and_stop();
  end

  initial begin
    {sel, rd, hr, clr, addr, wdata, tx_start, bp_len} = '0;
    i_sys_rst = 1'b1;
    repeat (4) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_sat();
    report_and_stop();
  end
endmodule : bertc_top_tb
